/* hdl/pipe_hazard_ctrl.sv */
// hazard stalls, stage tracking, branch flushing and predictor control
`default_nettype none
module pipe_hazard_ctrl
    import hazard_pkg::*;
#(
    parameter int PRED_ENTRIES = PRED_ENTRIES_DEF,
    parameter bit USE_PRED = 1'b1,
    parameter bit FAULT_TOL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [1:0] depth_sel,
    input wire dec_info_t decode_stage,
    input wire logic multi_done,
    input wire logic [31:0] fetch_pc,
    input wire branch_info_t br_ex,
    input wire logic exc_valid,
    input wire logic [31:0] exc_pc,
    output logic stall_decode,
    output logic stall_m0,
    output logic irq_defer,
    output stage_info_t execute_stage_r,
    output stage_info_t memory_stage_zero_r,
    output stage_info_t memory_stage_one_r,
    output stage_info_t memory_stage_two_r,
    output stage_info_t memory_stage_three_r,
    output stage_info_t writeback_stage_r,
    output logic flush_fetch_r,
    output logic flush_decode_r,
    output logic flush_prefetch_r,
    output logic [31:0] redirect_pc_r,
    output logic pred_hit_r,
    output logic [31:0] pred_target_r,
    output logic pred_parity_err_r,
    output logic delay_slot_flag_r,
    output logic [31:0] branch_target_register_r,
    output logic [31:0] exception_return_address_reg_r
);
    ////////////////////////////////////////////////////////////////////////////
    // helpers
    ////////////////////////////////////////////////////////////////////////////

    // producer in stage s writes a register that decode reads, and is in set m
    function automatic logic feeds(stage_info_t s, logic [7:0] m, logic [4:0] a,
                                   logic [4:0] b);
        return s.valid && m[s.cls] && (s.dest != ZERO_REG) && (s.dest == a || s.dest == b);
    endfunction

    // instruction in stage s may still raise a precise exception
    function automatic logic excepts(stage_info_t s);
        return s.valid && s.exc_impl && SET_EXC[s.cls];
    endfunction

    // saturating two-bit prediction counter
    function automatic logic [1:0] ctr_step(logic [1:0] c, logic up);
        if (up) begin
            return (c == 2'h3) ? c : c + 2'h1;
        end
        return (c == 2'h0) ? c : c - 2'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // hazard detection
    ////////////////////////////////////////////////////////////////////////////

    logic eight, five; // pipeline depth decoded
    logic haz_ex, haz_m0, haz_m12, haz_m3, haz_stream; // decode hazards
    logic ex_busy; // multi-cycle op still working in execute
    logic hold_ex; // execute cannot pass its instruction on
    logic [4:0] sa, sb; // decode source registers
    logic [7:0] mc_set; // multi-cycle categories for this depth

    assign eight = (depth_sel == DEPTH_EIGHT);
    assign five = (depth_sel == DEPTH_FIVE);
    assign sa = decode_stage.src_a;
    assign sb = decode_stage.src_b;

    // each source of stall is computed on its own; the or of them stalls for
    // as long as the longest one lasts, never for the sum
    always_comb begin
        haz_ex = 1'b0;
        haz_m0 = 1'b0;
        haz_m12 = 1'b0;
        haz_m3 = 1'b0;
        haz_stream = 1'b0;
        stall_m0 = 1'b0;
        mc_set = SET_MC3;
        if (decode_stage.op.valid && eight) begin
            haz_ex = feeds(execute_stage_r, SET_EX, sa, sb);
            haz_m0 = feeds(memory_stage_zero_r, SET_M0, sa, sb);
            haz_m12 = feeds(memory_stage_one_r, SET_M12, sa, sb)
                || feeds(memory_stage_two_r, SET_M12, sa, sb);
            haz_m3 = feeds(memory_stage_three_r, SET_M3, sa, sb);
            haz_stream = decode_stage.is_stream && (excepts(execute_stage_r)
                || excepts(memory_stage_zero_r) || excepts(memory_stage_one_r)
                || excepts(memory_stage_two_r) || excepts(memory_stage_three_r));
        end else if (decode_stage.op.valid && five) begin
            // add after multiply waits in decode until the product leaves memory
            haz_ex = feeds(execute_stage_r, SET_EX, sa, sb);
            haz_m0 = feeds(memory_stage_zero_r, SET_MEM5, sa, sb);
        end
        if (eight) begin
            mc_set = SET_MC8;
            stall_m0 = memory_stage_zero_r.valid && SET_LDST[memory_stage_zero_r.cls]
                && (excepts(memory_stage_one_r) || excepts(memory_stage_two_r)
                || excepts(memory_stage_three_r));
        end else if (five) begin
            mc_set = SET_MC5;
        end
    end

    assign ex_busy = execute_stage_r.valid && mc_set[execute_stage_r.cls] && !multi_done;
    assign hold_ex = ex_busy || stall_m0;
    // longest hazard wins through the or
    assign stall_decode = haz_ex || haz_m0 || haz_m12 || haz_m3 || haz_stream
        || hold_ex;

    ////////////////////////////////////////////////////////////////////////////
    // stage tracking
    ////////////////////////////////////////////////////////////////////////////

    stage_info_t ex_nxt, m0_nxt, m1_nxt, m2_nxt, m3_nxt, wb_nxt;
    logic cacheable, pred_ok, mispred, need_flush; // branch outcome, see below
    logic ffetch_nxt, fdec_nxt, fpre_nxt, cache_en; // flush decisions, see below
    localparam stage_info_t BUBBLE = '{valid: 1'b0, dest: ZERO_REG, cls: CLS_ALU,
        exc_impl: 1'b0};

    // advance: a stalled stage and those before it hold, the next gets a bubble,
    // later stages keep moving
    always_comb begin
        m1_nxt = memory_stage_zero_r;
        m2_nxt = memory_stage_one_r;
        m3_nxt = memory_stage_two_r;
        wb_nxt = eight ? memory_stage_three_r
            : (five ? memory_stage_zero_r : execute_stage_r);
        m0_nxt = execute_stage_r;
        ex_nxt = decode_stage.op;
        if (stall_m0) begin
            m1_nxt = BUBBLE;
            m0_nxt = memory_stage_zero_r;
            ex_nxt = execute_stage_r;
        end else if (ex_busy) begin
            m0_nxt = BUBBLE;
            ex_nxt = execute_stage_r;
        end else if (stall_decode || flush_decode_r || fdec_nxt || !decode_stage.op.valid) begin
            // a resolving branch that flushes decode (fdec_nxt) also kills what sits in decode right now
            ex_nxt = BUBBLE;
        end
        if (!eight) begin
            // shorter pipelines leave the extra memory stages empty
            m1_nxt = BUBBLE;
            m2_nxt = BUBBLE;
            m3_nxt = BUBBLE;
        end
        if (depth_sel == DEPTH_THREE) begin
            m0_nxt = BUBBLE;
        end
    end

    // stage registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            execute_stage_r <= BUBBLE;
            memory_stage_zero_r <= BUBBLE;
            memory_stage_one_r <= BUBBLE;
            memory_stage_two_r <= BUBBLE;
            memory_stage_three_r <= BUBBLE;
            writeback_stage_r <= BUBBLE;
        end else begin
            execute_stage_r <= ex_nxt;
            memory_stage_zero_r <= m0_nxt;
            memory_stage_one_r <= m1_nxt;
            memory_stage_two_r <= m2_nxt;
            memory_stage_three_r <= m3_nxt;
            writeback_stage_r <= wb_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // branch resolution and redirect
    ////////////////////////////////////////////////////////////////////////////

    logic [31:0] fall_pc, correct_pc, redir_nxt;
    logic [1:0] ctr_new;

    assign cache_en = USE_PRED && (depth_sel == DEPTH_THREE || eight);
    assign cacheable = br_ex.valid && (br_ex.is_imm || br_ex.is_return);
    assign fall_pc = br_ex.pc + (br_ex.delay_slot ? PC_STEP_DS : PC_STEP);
    assign correct_pc = br_ex.taken ? br_ex.target : fall_pc;
    // prediction matched both direction and, when taken, the target
    assign pred_ok = br_ex.predicted && cache_en && (br_ex.pred_taken == br_ex.taken)
        && (!br_ex.taken || br_ex.pred_target == br_ex.target);
    assign mispred = br_ex.valid && br_ex.predicted && !pred_ok;
    assign need_flush = br_ex.valid && !pred_ok && (br_ex.taken || mispred);
    assign ctr_new = ctr_step(br_ex.predicted ? {br_ex.pred_taken, 1'b0} : CTR_INIT,
        br_ex.taken);

    // flush decisions; a delay-slot branch spares decode unless it mispredicted
    always_comb begin
        ffetch_nxt = 1'b0;
        fdec_nxt = 1'b0;
        fpre_nxt = 1'b0;
        redir_nxt = redirect_pc_r;
        if (need_flush) begin
            ffetch_nxt = 1'b1;
            fpre_nxt = 1'b1;
            fdec_nxt = !br_ex.delay_slot || mispred;
            redir_nxt = correct_pc;
        end
    end

    // flush strobes last one cycle; together with the resolve cycle this gives
    // the two refill cycles of a taken branch
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            flush_fetch_r <= 1'b0;
            flush_decode_r <= 1'b0;
            flush_prefetch_r <= 1'b0;
            redirect_pc_r <= ADDR_RESET;
        end else begin
            flush_fetch_r <= ffetch_nxt;
            flush_decode_r <= fdec_nxt;
            flush_prefetch_r <= fpre_nxt;
            redirect_pc_r <= redir_nxt;
        end
    end

    // predictor; while cache_en, learns every cacheable branch that does not clear the cache, writing back corrected state
    pred_cache #(
        .ENTRIES(PRED_ENTRIES),
        .FAULT_TOL(FAULT_TOL)
    ) u_cache (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .enable(cache_en),
        .fetch_pc(fetch_pc),
        .wr_en(cache_en && cacheable && !br_ex.clears_cache),
        .wr_pc(br_ex.pc),
        .wr_target(br_ex.target),
        .wr_ctr(ctr_new),
        .wr_uncond(br_ex.is_return || !br_ex.is_cond),
        .clear(br_ex.clears_cache),
        .hit_r(pred_hit_r),
        .target_r(pred_target_r),
        .parity_err_r(pred_parity_err_r)
    );

    ////////////////////////////////////////////////////////////////////////////
    // delay slot and exception bookkeeping
    ////////////////////////////////////////////////////////////////////////////

    logic ds_pend_r, ds_pend_nxt, dsf_nxt;
    logic [31:0] ds_tgt_r, ds_tgt_nxt, btr_nxt, ret_nxt;

    // a delay-slot branch arms the window; the slot leaving execute closes it
    always_comb begin
        ds_pend_nxt = ds_pend_r;
        ds_tgt_nxt = ds_tgt_r;
        dsf_nxt = delay_slot_flag_r;
        btr_nxt = branch_target_register_r;
        ret_nxt = exception_return_address_reg_r;
        if (br_ex.valid && br_ex.delay_slot && !hold_ex) begin
            ds_pend_nxt = 1'b1;
            ds_tgt_nxt = correct_pc;
        end else if (ds_pend_r && execute_stage_r.valid && !hold_ex) begin
            ds_pend_nxt = 1'b0;
        end
        if (exc_valid && ds_pend_r) begin
            dsf_nxt = 1'b1;
            btr_nxt = ds_tgt_r;
        end else if (exc_valid) begin
            dsf_nxt = 1'b0;
            ret_nxt = exc_pc + PC_STEP;
        end
    end

    // no interrupt or hardware break may land between branch and slot
    assign irq_defer = ds_pend_r || (br_ex.valid && br_ex.delay_slot);

    // bookkeeping registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ds_pend_r <= 1'b0;
            ds_tgt_r <= ADDR_RESET;
            delay_slot_flag_r <= 1'b0;
            branch_target_register_r <= ADDR_RESET;
            exception_return_address_reg_r <= ADDR_RESET;
        end else begin
            ds_pend_r <= ds_pend_nxt;
            ds_tgt_r <= ds_tgt_nxt;
            delay_slot_flag_r <= dsf_nxt;
            branch_target_register_r <= btr_nxt;
            exception_return_address_reg_r <= ret_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_ex_hazard: assert property (eight && decode_stage.op.valid && !hold_ex
        && feeds(execute_stage_r, SET_EX, sa, sb) |=> !execute_stage_r.valid)
        else $error("execute producer did not stall decode");
    chk_m0_hazard: assert property (eight && decode_stage.op.valid && !hold_ex
        && feeds(memory_stage_zero_r, SET_M0, sa, sb) |=> !execute_stage_r.valid)
        else $error("m0 producer did not stall decode");
    chk_m3_hazard: assert property (eight && decode_stage.op.valid
        && feeds(memory_stage_three_r, SET_M3, sa, sb) && !hold_ex
        |=> !execute_stage_r.valid)
        else $error("m3 hazard let consumer into execute");
    chk_stream_wait: assert property (eight && decode_stage.op.valid && !hold_ex
        && decode_stage.is_stream && excepts(memory_stage_two_r)
        |=> !execute_stage_r.valid)
        else $error("stream op not held behind excepting op");
    chk_m0_hold: assert property (stall_m0 |=> !memory_stage_one_r.valid
        && memory_stage_zero_r == $past(memory_stage_zero_r))
        else $error("m0 structural stall did not hold and bubble");
    chk_stall_bubble: assert property (stall_decode && !hold_ex
        |=> !execute_stage_r.valid)
        else $error("stalled decode leaked into execute");
    chk_taken_flush: assert property (br_ex.valid && br_ex.taken && !br_ex.delay_slot
        && !br_ex.predicted |=> flush_fetch_r && flush_decode_r && flush_prefetch_r
        ##1 !flush_fetch_r)
        else $error("taken branch flush wrong");
    chk_slot_flush: assert property (br_ex.valid && br_ex.taken && br_ex.delay_slot
        && !br_ex.predicted |=> flush_fetch_r && !flush_decode_r)
        else $error("delay slot was flushed");
    chk_pred_free: assert property (br_ex.valid && pred_ok |=> !flush_fetch_r)
        else $error("correct prediction caused a flush");
    chk_irq_defer: assert property (br_ex.valid && br_ex.delay_slot && !hold_ex
        |=> irq_defer)
        else $error("interrupt not deferred over delay slot");
    chk_ds_exc: assert property (exc_valid && ds_pend_r |=> delay_slot_flag_r
        && branch_target_register_r == $past(ds_tgt_r))
        else $error("delay slot exception bookkeeping wrong");

    cov_taken_plain: cover property (br_ex.valid && br_ex.taken && !br_ex.delay_slot);
    cov_mispredict: cover property (mispred ##1 flush_fetch_r);
    cov_long_stall: cover property (stall_decode [*5]);
    cov_slot_exc: cover property (exc_valid && ds_pend_r);
endmodule
`default_nettype wire

/* hdl/hazard_pkg.sv */
// constants, types and carriers for the pipeline hazard and branch control
`default_nettype none
package hazard_pkg;
    localparam logic [1:0] DEPTH_THREE = 2'h0; // area pipeline
    localparam logic [1:0] DEPTH_FIVE = 2'h1; // performance pipeline
    localparam logic [1:0] DEPTH_EIGHT = 2'h2; // frequency pipeline
    localparam int ADDR_W = 32; // fetch address width
    localparam int PRED_ENTRIES_DEF = 512; // default predictor depth
    localparam int DIST_LIMIT = 64; // at or below: distributed storage
    localparam logic [31:0] PC_STEP = 32'h0000_0004; // one instruction
    localparam logic [31:0] PC_STEP_DS = 32'h0000_0008; // branch plus slot
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000; // address regs after reset
    localparam logic [1:0] CTR_INIT = 2'h2; // weakly taken on first learn
    localparam logic [4:0] ZERO_REG = 5'h00; // hard-wired zero register

    // operation categories that matter for hazards
    typedef enum logic [2:0] {
        CLS_ALU, CLS_LOAD, CLS_STORE, CLS_SHIFT, CLS_MUL, CLS_DIV, CLS_FP_MULTI, CLS_FP
    } op_cls_t;

    // category sets, indexed by op_cls_t
    localparam logic [7:0] SET_EX = 8'hFE; // everything but plain alu
    localparam logic [7:0] SET_M0 = 8'hF2; // load, mul, div, fp
    localparam logic [7:0] SET_M12 = 8'hE2; // load, div, fp
    localparam logic [7:0] SET_M3 = 8'hC2; // load, fp
    localparam logic [7:0] SET_MEM5 = 8'hD2; // five-stage memory: load, mul, fp
    localparam logic [7:0] SET_EXC = 8'hE6; // load, store, div, fp
    localparam logic [7:0] SET_LDST = 8'h06; // load, store
    localparam logic [7:0] SET_MC8 = 8'h60; // eight-stage multi-cycle
    localparam logic [7:0] SET_MC5 = 8'hE0; // five-stage multi-cycle
    localparam logic [7:0] SET_MC3 = 8'hF8; // three-stage multi-cycle: shift, mul, div, fp

    // one instruction as it sits in a stage
    typedef struct packed {
        logic valid;
        logic [4:0] dest;
        op_cls_t cls;
        logic exc_impl; // its exception is implemented
    } stage_info_t;

    // instruction offered by decode
    typedef struct packed {
        logic [4:0] src_a;
        logic [4:0] src_b;
        logic is_stream;
        stage_info_t op;
    } dec_info_t;

    // branch resolution seen in execute
    typedef struct packed {
        logic valid; // a branch sits in execute this cycle
        logic is_imm; // immediate branch: cacheable
        logic is_return; // return: cacheable, always taken
        logic is_cond;
        logic delay_slot;
        logic taken;
        logic predicted; // fetch followed a cache hit
        logic pred_taken;
        logic [31:0] pc;
        logic [31:0] target;
        logic [31:0] pred_target;
        logic clears_cache; // barrier 0 or sync branch with offset 4
    } branch_info_t;
endpackage
`default_nettype wire

/* hdl/pred_cache.sv */
// branch predictor cache: targets, two-bit counters and optional parity
`default_nettype none
module pred_cache
    import hazard_pkg::*;
#(
    parameter int ENTRIES = PRED_ENTRIES_DEF,
    parameter bit FAULT_TOL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [31:0] fetch_pc,
    input wire logic wr_en,
    input wire logic [31:0] wr_pc,
    input wire logic [31:0] wr_target,
    input wire logic [1:0] wr_ctr,
    input wire logic wr_uncond,
    input wire logic clear,
    output logic hit_r,
    output logic [31:0] target_r,
    output logic parity_err_r
);
    localparam int IDX_W = $clog2(ENTRIES);
    localparam int TAG_W = ADDR_W - IDX_W - 2;
    localparam bit USE_PAR = FAULT_TOL && (ENTRIES > DIST_LIMIT);

    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic [31:0] target;
        logic [1:0] ctr;
        logic uncond;
        logic par;
    } entry_t;

    entry_t mem [ENTRIES]; // target storage, not reset
    logic [ENTRIES-1:0] valid_r, valid_nxt; // cleared at once by barrier
    logic hit_nxt, perr_nxt;
    logic [31:0] target_nxt;
    entry_t rd;
    logic [IDX_W-1:0] rd_idx, wr_idx;

    // even parity over the stored fields
    function automatic logic par_of(entry_t e);
        return ^{e.tag, e.target, e.ctr, e.uncond};
    endfunction

    assign rd_idx = fetch_pc[IDX_W+1:2];
    assign wr_idx = wr_pc[IDX_W+1:2];
    assign rd = mem[rd_idx];

    // lookup: redirect always for unconditional, by counter otherwise
    always_comb begin
        perr_nxt = USE_PAR && valid_r[rd_idx] && (par_of(rd) != rd.par);
        hit_nxt = enable && valid_r[rd_idx] && (rd.tag == fetch_pc[31:IDX_W+2])
            && (rd.uncond || rd.ctr[1]) && !perr_nxt;
        target_nxt = rd.target;
        valid_nxt = valid_r;
        if (wr_en) begin
            valid_nxt[wr_idx] = 1'b1;
        end
        // clearing wins: a learn in the same cycle is dropped
        if (clear) begin
            valid_nxt = '0;
        end
    end

    // storage write, no reset so it can map onto memory primitives
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= '{tag: wr_pc[31:IDX_W+2], target: wr_target, ctr: wr_ctr,
                uncond: wr_uncond,
                par: ^{wr_pc[31:IDX_W+2], wr_target, wr_ctr, wr_uncond}};
        end
    end

    // registered read, one cycle like a block memory port
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            valid_r <= '0;
            hit_r <= 1'b0;
            target_r <= ADDR_RESET;
            parity_err_r <= 1'b0;
        end else begin
            valid_r <= valid_nxt;
            hit_r <= hit_nxt;
            target_r <= target_nxt;
            parity_err_r <= perr_nxt;
        end
    end
endmodule
`default_nettype wire

/* test/fetch_model.sv */
// decode feeder standing in for the fetch side
`default_nettype none
module fetch_model
    import hazard_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic stall_decode,
    input wire logic push,
    input wire dec_info_t push_op,
    output var dec_info_t decode_stage
);
    timeunit 1ns;
    timeprecision 1ns;
    // a stalled instruction is held, since the control never takes it
    always @(posedge ref_clk) begin
        if (!resetn) begin
            decode_stage <= '0;
        end else if (!stall_decode) begin
            decode_stage <= push_op;
            decode_stage.op.valid <= push;
        end
    end
endmodule
`default_nettype wire

/* test/pipe_hazard_ctrl_tb.sv */
// self-checking bench for the hazard and branch control
`default_nettype none
module pipe_hazard_ctrl_tb import hazard_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, resetn = 0, push = 0, exc_valid = 0, multi_done = 1;
    logic [1:0] depth = DEPTH_EIGHT;
    logic [31:0] fetch_pc = '0, exc_pc = '0, rnd = 32'hCC25, pc, tg;
    dec_info_t push_op = '0, decode_stage, ld, st;
    branch_info_t br_ex = '0;
    logic stall_decode, flush_fetch_r, flush_decode_r, flush_prefetch_r, pred_hit_r;
    logic delay_slot_flag_r, irq_defer, stall_m0;
    logic [31:0] redirect_pc_r, pred_target_r, exception_return_address_reg_r;
    logic [31:0] branch_target_register_r;
    int mismatches = 0, comparisons = 0, n;
    always #25 ref_clk = ~ref_clk;
    fetch_model i_fetch_model (.ref_clk, .resetn, .stall_decode, .push, .push_op, .decode_stage);
    pipe_hazard_ctrl i_pipe_hazard_ctrl (.ref_clk, .resetn, .depth_sel(depth),
        .decode_stage, .multi_done, .fetch_pc, .br_ex, .exc_valid, .exc_pc,
        .stall_decode, .stall_m0, .irq_defer, .execute_stage_r(), .memory_stage_zero_r(),
        .memory_stage_one_r(), .memory_stage_two_r(), .memory_stage_three_r(),
        .writeback_stage_r(), .flush_fetch_r, .flush_decode_r, .flush_prefetch_r,
        .redirect_pc_r, .pred_hit_r, .pred_target_r, .pred_parity_err_r(),
        .delay_slot_flag_r, .branch_target_register_r, .exception_return_address_reg_r);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k = 1);
        repeat (k) @(posedge ref_clk);
        #5;
    endtask
    // push two ops back to back, skip w cycles, count cycles of the chosen stall
    task automatic pair(input dec_info_t a, input dec_info_t b, input int w, input bit m0);
        push = 1;
        push_op = a;
        tick();
        push_op = b;
        tick();
        push = 0;
        if (w > 0) begin
            tick(w);
        end
        n = 0;
        while ((m0 ? stall_m0 : stall_decode) === 1'b1 && n < 20) begin
            n++;
            tick();
        end
    endtask
    task automatic br(input logic [7:0] f, input logic clr);
        br_ex = {f, pc, tg, tg, clr};
        tick();
        br_ex = '0;
    endtask
    task automatic tally_and_finish();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic dec_info_t mk(input op_cls_t c, input logic [4:0] s, input logic [4:0] d);
        mk = '0;
        mk.src_a = s;
        mk.op = '{1'b1, d, c, 1'b0};
    endfunction
    // stall length seen by a dependent add: one cycle per stage that hazards
    function automatic int exp_stall(input op_cls_t c);
        return int'(c != CLS_ALU) + int'(c inside {CLS_LOAD, CLS_MUL, CLS_DIV, CLS_FP_MULTI, CLS_FP})
            + 2 * int'(c inside {CLS_LOAD, CLS_DIV, CLS_FP_MULTI, CLS_FP})
            + int'(c inside {CLS_LOAD, CLS_FP_MULTI, CLS_FP});
    endfunction
    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        tick(4);
        resetn = 1;
        // every producer kind followed by an add reading its random destination
        for (int c = 0; c < 8; c++) begin
            rnd = lfsr(rnd);
            pair(mk(op_cls_t'(c), 5'h00, rnd[4:0] | 5'h01),
                mk(CLS_ALU, rnd[4:0] | 5'h01, 5'h00), 0, 1'b0);
            chk(n, exp_stall(op_cls_t'(c)));
            tick(8);
        end
        // excepting load ahead of a stream op, then ahead of a second load
        ld = mk(CLS_LOAD, 5'h00, 5'h03);
        ld.op.exc_impl = 1'b1;
        st = mk(CLS_ALU, 5'h00, 5'h00);
        st.is_stream = 1'b1;
        pair(ld, st, 0, 1'b0);
        chk(n, 5);
        tick(8);
        pair(ld, ld, 2, 1'b1);
        chk(n, 3);
        tick(8);
        // unfinished divide holds execute, a shift does not
        multi_done = 0;
        pair(mk(CLS_SHIFT, 5'h00, 5'h00), mk(CLS_ALU, 5'h00, 5'h00), 0, 1'b0);
        chk(n, 0);
        tick(8);
        pair(mk(CLS_DIV, 5'h00, 5'h00), mk(CLS_ALU, 5'h00, 5'h00), 0, 1'b0);
        chk(n, 20);
        multi_done = 1;
        tick();
        chk(stall_decode, 1'b0);
        tick(8);
        pc = {rnd[31:2], 2'h0};
        tg = pc ^ 32'h0000_1F00;
        br(8'h84, 1'b0);
        chk({flush_fetch_r, flush_decode_r, flush_prefetch_r}, 3'h7);
        chk(redirect_pc_r, tg);
        tick();
        chk(flush_fetch_r, 1'b0);
        br(8'h8C, 1'b0);
        chk({flush_fetch_r, flush_decode_r}, 2'h2);
        chk(irq_defer, 1'b1);
        // exception inside the delay slot window
        exc_pc = pc;
        exc_valid = 1;
        tick();
        exc_valid = 0;
        chk(delay_slot_flag_r, 1'b1);
        chk(branch_target_register_r, tg);
        push = 1;
        tick();
        push = 0;
        tick(3);
        exc_pc = tg;
        exc_valid = 1;
        tick();
        exc_valid = 0;
        chk(delay_slot_flag_r, 1'b0);
        chk(exception_return_address_reg_r, tg + 32'h4);
        // learn, hit, correct prediction, then barrier clear
        br(8'hC4, 1'b0);
        fetch_pc = pc;
        tick(2);
        chk(pred_hit_r, 1'b1);
        chk(pred_target_r, tg);
        br(8'hC7, 1'b0);
        chk(flush_fetch_r, 1'b0);
        br(8'h80, 1'b1);
        tick(2);
        chk(pred_hit_r, 1'b0);
        // five-stage add behind a multiply waits two cycles in decode
        depth = DEPTH_FIVE;
        pair(mk(CLS_MUL, 5'h00, 5'h03), mk(CLS_ALU, 5'h03, 5'h00), 0, 1'b0);
        chk(n, 2);
        tally_and_finish();
    end
endmodule
`default_nettype wire
